// ==== design/lbpp_boot_handler.sv ====
// lbpp_boot_handler.sv: link boot, peek and poke command handler.
// assumes rx/tx byte streams and memory port run on clk; strap is an asynchronous pin.
// Function
// - strap high boots rom, low awaits link
// - header 2..255 downloads exactly that many bytes
// - store bytes from base, then start there
// - start low priority, workspace above code
// - header zero writes addressed word
// - header one returns addressed word on link
// - after peek or poke await new header
`include "lbpp_params.svh"
`timescale 1ns/100ps
`default_nettype none

module lbpp_boot_handler
    import lbpp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic boot_source_strap,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic boot_rom,
    output logic exec_start,
    output logic [31:0] exec_addr,
    output logic [31:0] exec_wptr,
    output logic exec_low_pri
);
    // synchronised reset and strap
    logic rst_n;
    logic strap_s;
    // state and datapath registers
    lbpp_state_t state_r, state_nxt;
    logic [7:0] cnt_r;        // remaining code bytes, or field byte index
    logic [31:0] addr_r;      // running load address or collected address
    logic [31:0] data_r;      // code byte, poke data or peek reply
    logic [1:0] wait_r;       // strap settle counter
    logic is_peek_r;          // address phase belongs to a peek
    logic [31:0] wptr_r;      // workspace start
    logic start_r;            // one-cycle start pulse

    // reset release through two flip-flops
    lbpp_sync2 u_rst_sync (
        .clk(clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(rst_n)
    );

    // strap pin synchroniser
    lbpp_sync2 u_strap_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(boot_source_strap),
        .q(strap_s)
    );

    // handshake decodes
    wire rx_take = rx_valid && rx_ready;
    wire tx_take = tx_valid && tx_ready;
    wire field_last = (cnt_r[1:0] == `LBPP_FIELD_LAST);
    wire hdr_poke = (rx_data == `LBPP_HDR_POKE);
    wire hdr_peek = (rx_data == `LBPP_HDR_PEEK);
    wire load_last = (cnt_r == 8'h01);
    // workspace rounded up past the code
    wire [31:0] wptr_calc = (addr_r + `LBPP_WORD_ROUND + 32'h1) & `LBPP_WORD_MASK;

    // bytes accepted only where a byte is awaited
    assign rx_ready = (state_r == LBPP_ST_HDR) || (state_r == LBPP_ST_LOAD) ||
                      (state_r == LBPP_ST_ADDR) || (state_r == LBPP_ST_DATA);
    // reply offered while in reply state
    assign tx_valid = (state_r == LBPP_ST_REPLY);
    assign tx_data = data_r[7:0];
    // memory request held until acknowledged
    assign mem_req = (state_r == LBPP_ST_LWR) || (state_r == LBPP_ST_MWR) ||
                     (state_r == LBPP_ST_MRD);
    assign mem_we = (state_r != LBPP_ST_MRD);
    assign mem_addr = addr_r;
    // code byte replicated on all lanes
    assign mem_wdata = (state_r == LBPP_ST_LWR) ? {4{data_r[7:0]}} : data_r;
    assign mem_be = (state_r == LBPP_ST_LWR) ? lbpp_lane_be(addr_r[1:0]) : `LBPP_BE_ALL;
    // rom boot shown as a level
    assign boot_rom = (state_r == LBPP_ST_ROM);
    assign exec_start = start_r;
    assign exec_addr = `LBPP_LOAD_BASE;
    assign exec_wptr = wptr_r;
    assign exec_low_pri = (state_r == LBPP_ST_RUN);

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LBPP_ST_STRAP: begin
                if (wait_r == `LBPP_STRAP_WAIT) begin
                    state_nxt = strap_s ? LBPP_ST_ROM : LBPP_ST_HDR;
                end
            end
            LBPP_ST_HDR: begin
                if (rx_take) begin
                    state_nxt = (hdr_poke || hdr_peek) ? LBPP_ST_ADDR : LBPP_ST_LOAD;
                end
            end
            LBPP_ST_LOAD: begin
                if (rx_take) begin
                    state_nxt = LBPP_ST_LWR;
                end
            end
            LBPP_ST_LWR: begin
                if (mem_ack) begin
                    state_nxt = load_last ? LBPP_ST_RUN : LBPP_ST_LOAD;
                end
            end
            LBPP_ST_ADDR: begin
                if (rx_take && field_last) begin
                    state_nxt = is_peek_r ? LBPP_ST_MRD : LBPP_ST_DATA;
                end
            end
            LBPP_ST_DATA: begin
                if (rx_take && field_last) begin
                    state_nxt = LBPP_ST_MWR;
                end
            end
            LBPP_ST_MWR: begin
                if (mem_ack) begin
                    state_nxt = LBPP_ST_HDR;
                end
            end
            LBPP_ST_MRD: begin
                if (mem_ack) begin
                    state_nxt = LBPP_ST_REPLY;
                end
            end
            LBPP_ST_REPLY: begin
                if (tx_take && field_last) begin
                    state_nxt = LBPP_ST_HDR;
                end
            end
            default: begin
                // rom and run states hold
                state_nxt = state_r;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= LBPP_ST_STRAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // strap settle counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 2'h0;
        end else if (state_r == LBPP_ST_STRAP) begin
            wait_r <= wait_r + 2'h1;
        end
    end

    // byte counter: code bytes left, or field index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else if (state_r == LBPP_ST_HDR) begin
            cnt_r <= (rx_take && !hdr_poke && !hdr_peek) ? rx_data : 8'h00;
        end else if (state_r == LBPP_ST_LWR && mem_ack) begin
            cnt_r <= cnt_r - 8'h01;
        end else if ((rx_take && state_r != LBPP_ST_LOAD) || tx_take) begin
            // field index only; code bytes are counted down on their write
            cnt_r <= {6'h00, cnt_r[1:0] + 2'h1};
        end
    end

    // address: load pointer or collected address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 32'h0;
            is_peek_r <= 1'b0;
        end else if (state_r == LBPP_ST_HDR && rx_take) begin
            addr_r <= `LBPP_LOAD_BASE;
            is_peek_r <= hdr_peek;
        end else if (state_r == LBPP_ST_ADDR && rx_take) begin
            addr_r <= lbpp_shift_in(addr_r, rx_data);
        end else if (state_r == LBPP_ST_LWR && mem_ack) begin
            addr_r <= addr_r + 32'h1;
        end
    end

    // data: code byte, poke word, or peek reply
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_r <= 32'h0;
        end else if (state_r == LBPP_ST_LOAD && rx_take) begin
            data_r <= {24'h0, rx_data};
        end else if (state_r == LBPP_ST_DATA && rx_take) begin
            data_r <= lbpp_shift_in(data_r, rx_data);
        end else if (state_r == LBPP_ST_MRD && mem_ack) begin
            data_r <= mem_rdata;
        end else if (tx_take) begin
            data_r <= {8'h00, data_r[31:8]};
        end
    end

    // start pulse and workspace pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_r <= 1'b0;
            wptr_r <= 32'h0;
        end else begin
            start_r <= (state_r == LBPP_ST_LWR) && mem_ack && load_last;
            if ((state_r == LBPP_ST_LWR) && mem_ack && load_last) begin
                wptr_r <= wptr_calc;
            end
        end
    end

    // start follows only the last code write
    AST_START_AFTER_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        exec_start |-> $past(state_r) == LBPP_ST_LWR && state_r == LBPP_ST_RUN)
        else $error("start without final code write");
    AST_START_BASE: assert property (@(posedge clk) disable iff (!rst_n)
        exec_start |-> exec_addr == `LBPP_LOAD_BASE && exec_low_pri)
        else $error("start address or priority wrong");
    AST_WPTR_ABOVE: assert property (@(posedge clk) disable iff (!rst_n)
        exec_start |-> exec_wptr > `LBPP_LOAD_BASE && exec_wptr[1:0] == 2'h0)
        else $error("workspace not above code");
    AST_ROM_BOOT: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == LBPP_ST_STRAP && state_nxt != LBPP_ST_STRAP |->
        ##1 boot_rom == $past(strap_s) && rx_ready == !$past(strap_s))
        else $error("boot source not per strap");
    AST_LOAD_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == LBPP_ST_HDR && rx_take && rx_data > `LBPP_HDR_PEEK |->
        ##1 state_r == LBPP_ST_LOAD && cnt_r == $past(rx_data))
        else $error("code count not loaded");
    AST_POKE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == LBPP_ST_MWR |-> mem_req && mem_we && mem_be == `LBPP_BE_ALL)
        else $error("poke not a full word write");
    AST_PEEK_READ: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == LBPP_ST_MRD && mem_ack |-> ##1 tx_valid && tx_data == $past(mem_rdata[7:0]))
        else $error("peek reply wrong");
    AST_BACK_TO_HDR: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == LBPP_ST_MWR && mem_ack |=> state_r == LBPP_ST_HDR && rx_ready)
        else $error("no return to header");
    AST_ADDR_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == LBPP_ST_ADDR && rx_take |=> addr_r[31:24] == $past(rx_data))
        else $error("address byte order wrong");
endmodule : lbpp_boot_handler

`default_nettype wire

// ==== design/lbpp_params.svh ====
// lbpp_params.svh: constants of the link boot, peek and poke handler.
// assumes byte-wide receive/transmit streams and a 32-bit byte-addressed memory port.
`ifndef LBPP_PARAMS_SVH
`define LBPP_PARAMS_SVH

// start address of downloaded code
`define LBPP_LOAD_BASE 32'h80000048
// header values that select a single word access
`define LBPP_HDR_POKE 8'h00
`define LBPP_HDR_PEEK 8'h01
// last index of a four-byte address or data field
`define LBPP_FIELD_LAST 2'h3
// settle counter value at which the strap is read, in the third cycle of waiting
`define LBPP_STRAP_WAIT 2'h2
// all byte lanes of a word
`define LBPP_BE_ALL 4'hF
// mask that clears the two byte-offset bits of an address
`define LBPP_WORD_MASK 32'hFFFFFFFC
// largest byte offset within a word, used to round up to a word
`define LBPP_WORD_ROUND 32'h00000003

`endif

// ==== design/lbpp_pkg.sv ====
// lbpp_pkg.sv: types and helpers shared by the link boot handler.
// assumes lbpp_params.svh is on the include path.
`include "lbpp_params.svh"

package lbpp_pkg;

    // handler states
    typedef enum logic [3:0] {
        LBPP_ST_STRAP = 4'h0, // waiting for the boot strap to settle
        LBPP_ST_ROM   = 4'h1, // booting from rom, handler idle for good
        LBPP_ST_HDR   = 4'h2, // awaiting a header byte
        LBPP_ST_LOAD  = 4'h3, // awaiting a code byte
        LBPP_ST_LWR   = 4'h4, // writing one code byte
        LBPP_ST_ADDR  = 4'h5, // collecting address bytes
        LBPP_ST_DATA  = 4'h6, // collecting poke data bytes
        LBPP_ST_MWR   = 4'h7, // poke word write
        LBPP_ST_MRD   = 4'h8, // peek word read
        LBPP_ST_REPLY = 4'h9, // sending peek bytes
        LBPP_ST_RUN   = 4'hA  // code started, handler idle
    } lbpp_state_t;

    // byte enable for one byte lane
    function automatic logic [3:0] lbpp_lane_be(input logic [1:0] lane);
        lbpp_lane_be = 4'h1 << lane;
    endfunction : lbpp_lane_be

    // shift a new byte into the top of a field collected low byte first
    function automatic logic [31:0] lbpp_shift_in(input logic [31:0] field,
                                                  input logic [7:0] b);
        lbpp_shift_in = {b, field[31:8]};
    endfunction : lbpp_shift_in

endpackage : lbpp_pkg

// ==== design/lbpp_sync2.sv ====
// lbpp_sync2.sv: two flip-flop synchroniser for one level.
// assumes d comes from outside the clk domain; rst_n is asynchronous, active low.
`timescale 1ns/100ps
`default_nettype none

module lbpp_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    // first stage, read only by the second stage
    logic meta_r;

    // two stages, cleared to zero by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : lbpp_sync2

`default_nettype wire

// ==== tb/lbpp_boot_handler_tb.sv ====
// lbpp_boot_handler_tb.sv: self-checking bench of the link boot handler.
// assumes lbpp_params.svh on the include path; memory is modelled here.
`include "lbpp_params.svh"
`timescale 1ns/100ps
`default_nettype none

module lbpp_boot_handler_tb;
    import lbpp_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, strap = 1'b0, slow = 1'b0; // bench controls
    logic rx_valid, rx_ready, tx_valid, tx_ready, mem_req, mem_we, mem_ack = 1'b0;
    logic [7:0] rx_data, tx_data; // link bytes
    logic [31:0] mem_addr, mem_wdata, mem_rdata = 32'h0, exec_addr, exec_wptr, exp_wptr;
    logic [3:0] mem_be; // byte enables
    logic boot_rom, exec_start, exec_low_pri, exec_armed = 1'b0; // start outputs
    logic [31:0] mem [logic [31:0]]; // word memory
    logic [67:0] exp_w [$]; // expected writes: addr, be, masked data
    logic [7:0] exp_tx [$]; // expected reply bytes
    logic [67:0] w; // popped write
    int n_mismatch = 0, n_tests = 0;

    lbpp_boot_handler uut (.clk(clk), .resetn(resetn), .boot_source_strap(strap),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .boot_rom(boot_rom), .exec_start(exec_start),
        .exec_addr(exec_addr), .exec_wptr(exec_wptr), .exec_low_pri(exec_low_pri));
    lbpp_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_ready(tx_ready), .slow(slow));

    // free-running clock
    always #5 clk = ~clk;

    // compare one value, count and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // byte lanes selected by an enable
    function automatic logic [31:0] bmask(input logic [3:0] be);
        bmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : bmask

    // memory: random ack delay, one-cycle pulse, scrambled data outside ack
    always @(negedge clk) begin
        if (mem_req === 1'b1 && !mem_ack && ($urandom % 2 == 0)) begin
            if (!mem.exists(mem_addr & `LBPP_WORD_MASK)) mem[mem_addr & `LBPP_WORD_MASK] = 32'h0;
            if (mem_we) mem[mem_addr & `LBPP_WORD_MASK] =
                (mem[mem_addr & `LBPP_WORD_MASK] & ~bmask(mem_be)) | (mem_wdata & bmask(mem_be));
            mem_rdata <= mem[mem_addr & `LBPP_WORD_MASK];
            mem_ack <= 1'b1;
        end else begin
            mem_rdata <= ~mem_rdata;
            mem_ack <= 1'b0;
        end
    end

    // watcher: each result takes the oldest note off its queue
    always @(posedge clk) begin
        if (resetn && mem_req && mem_ack && mem_we) begin
            if (exp_w.size() == 0) chk(32'h1, 32'h0);
            else begin
                w = exp_w.pop_front();
                chk(mem_addr, w[67:36]);
                chk({28'h0, mem_be}, {28'h0, w[35:32]});
                chk(mem_wdata & bmask(w[35:32]), w[31:0]);
            end
        end
        if (resetn && tx_valid && tx_ready) begin
            if (exp_tx.size() == 0) chk(32'h1, 32'h0);
            else chk({24'h0, tx_data}, {24'h0, exp_tx.pop_front()});
        end
        if (resetn && exec_start) begin
            chk({31'h0, exec_armed}, 32'h1);
            chk(exec_addr, `LBPP_LOAD_BASE);
            chk(exec_wptr, exp_wptr);
            chk({31'h0, exec_low_pri}, 32'h1);
            exec_armed = 1'b0;
        end
    end

    // reset with a strap level, then let synchronisers settle
    task automatic reset_dut(input logic s);
        @(negedge clk);
        resetn = 1'b0;
        strap = s;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (12) @(negedge clk);
    endtask : reset_dut

    // wait until every note has been matched
    task automatic drain();
        int n;
        n = 0;
        while ((exp_w.size() + exp_tx.size() != 0 || exec_armed) && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, n >= 5000}, 32'h0);
        chk({31'h0, host.stuck}, 32'h0);
    endtask : drain

    task automatic poke(input logic [31:0] a, input logic [31:0] d);
        exp_w.push_back({a, 4'hF, d});
        host.send(`LBPP_HDR_POKE);
        host.send_word(a);
        host.send_word(d);
        host.idle();
    endtask : poke

    task automatic peek(input logic [31:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) exp_tx.push_back(d[8*i +: 8]);
        host.send(`LBPP_HDR_PEEK);
        host.send_word(a);
        host.idle();
    endtask : peek

    // download n code bytes, then expect a start
    task automatic load(input int n);
        logic [7:0] b;
        logic [31:0] a;
        exp_wptr = (`LBPP_LOAD_BASE + n + 3) & `LBPP_WORD_MASK;
        exec_armed = 1'b1;
        host.send(n[7:0]);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            a = `LBPP_LOAD_BASE + i;
            exp_w.push_back({a, 4'h1 << a[1:0], {4{b}} & bmask(4'h1 << a[1:0])});
            host.send(b);
        end
        host.idle();
        drain();
        chk({31'h0, rx_ready}, 32'h0);
    endtask : load

    // main sequence
    initial begin
        logic [31:0] a, d0, d1;
        void'($urandom(45));
        reset_dut(1'b1);
        repeat (20) @(negedge clk);
        chk({30'h0, boot_rom, rx_ready}, 32'h2);
        reset_dut(1'b0);
        chk({30'h0, boot_rom, rx_ready}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            slow = k[0];
            a = $urandom & `LBPP_WORD_MASK;
            d0 = $urandom;
            d1 = $urandom;
            poke(a, d0);
            poke(a + 32'h4, d1);
            peek(a + 32'h4, d1);
            peek(a, d0);
        end
        drain();
        load(2);
        reset_dut(1'b0);
        load(255);
        wrap_up();
    end

    // watchdog
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end

    // verdict and end of run
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
endmodule : lbpp_boot_handler_tb

`default_nettype wire

// ==== tb/lbpp_host_model.sv ====
// lbpp_host_model.sv: host processor on the far side of the link byte streams.
// assumes the bench calls its tasks; bytes change only at falling clock edges.
`timescale 1ns/100ps
`default_nettype none

module lbpp_host_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    output logic tx_ready,
    input wire logic slow
);
    int n_wait; // cycles spent on one byte
    logic stuck = 1'b0; // a byte was never taken

    // idle stream at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end

    // reply bytes taken, stalling when slow
    always @(negedge clk) begin
        tx_ready <= slow ? ($urandom % 3 == 0) : 1'b1;
    end

    // release the stream, data shows the inverse of the last byte
    task automatic idle();
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask : idle

    // offer one byte and hold it until the handler takes it
    task automatic send(input logic [7:0] b);
        if (slow) begin
            idle();
            repeat ($urandom % 3) @(negedge clk);
        end
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = b;
        n_wait = 0;
        do begin
            @(posedge clk);
            n_wait++;
        end while (rx_ready !== 1'b1 && n_wait < 2000);
        if (n_wait >= 2000) stuck = 1'b1;
    endtask : send

    task automatic send_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) send(w[8*i +: 8]);
    endtask : send_word
endmodule : lbpp_host_model

`default_nettype wire
